// ---- rtl/two_wire_map.svh ----
/*
 constants of the two-wire slave port: address default, memory limits, bit slots.
 assumes inclusion by the port's package and modules only.
*/
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH

`define TW_ADDR_DEFAULT 7'h34
`define TW_WRITE_LAST 8'h4F
`define TW_READ_FILL 8'hFF
`define TW_PTR_LAST 8'hFF
`define TW_PTR_STEP 8'h01
`define TW_LSB_SLOT 4'h7
`define TW_ACK_SLOT 4'h8
`define TW_SLOT_ZERO 4'h0
`define TW_SLOT_STEP 4'h1
`define TW_SCL_MAX_KHZ 400

`endif

// ---- rtl/two_wire_pkg.sv ----
/*
 types of the two-wire slave port.
 assumes nothing beyond the constants header.
*/
package two_wire_pkg;
    `include "two_wire_map.svh"

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_PTR = 3'h2,
        ST_WRITE = 3'h3,
        ST_READ = 3'h4,
        ST_IGNORE = 3'h5
    } bus_state_type;
endpackage

// ---- rtl/level_sync.sv ----
/*
 two flip-flop synchroniser for a group of independent levels.
 assumes each bit is a level that may change at any time.
*/
`timescale 1ns/10ps
module level_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] hold_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // first stage feeds only the second; idle bus reads high
            always_ff @(posedge clk_in)
            begin
                if (!rstn_in)
                begin
                    meta_q[i] <= 1'b1;
                    hold_q[i] <= 1'b1;
                end
                else
                begin
                    meta_q[i] <= async_in[i];
                    hold_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = hold_q;
endmodule

// ---- rtl/link_bit_capture.sv ----
/*
 bit capture clocked by the serial clock itself: shifts the data line in on
 every rising serial clock edge and flips a toggle to announce the new bit.
 assumes the master keeps data steady around the rising edge, and that
 reset is released only while the bus is idle.
*/
`timescale 1ns/10ps
module link_bit_capture (
    // link clock and data
    input wire logic scl_in,
    input wire logic sda_in,
    // reset, applied without a serial clock
    input wire logic rstn_in,
    // captured bits
    output logic [7:0] shift_out,
    output logic toggle_out
);
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic toggle_q;
    logic toggle_d;

    always_comb
    begin
        // msb arrives first, so it ends up at the top after eight edges
        shift_d = {shift_q[6:0], sda_in};
        toggle_d = ~toggle_q;
    end

    // asynchronous: the serial clock stands still outside frames, and an
    // unreset toggle would never settle to a known level
    always_ff @(posedge scl_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            shift_q <= 8'h00;
            toggle_q <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            toggle_q <= toggle_d;
        end
    end

    assign shift_out = shift_q;
    assign toggle_out = toggle_q;
endmodule

// ---- rtl/two_wire_slave_port.sv ----
/*
 two-wire slave port: start/stop detection, address match, memory pointer,
 write and read strobes toward the register memory, open-drain data line.
 assumes a user memory on CLK_IN answering a read strobe one cycle later,
 an external pull-up on the data line, and a master on the serial clock.
*/
`timescale 1ns/10ps
`include "two_wire_map.svh"
module two_wire_slave_port (
    // system clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // serial link
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    // device address programming
    input wire logic ADDR_WR_IN,
    input wire logic [6:0] ADDR_VAL_IN,
    output logic [6:0] DEV_ADDR_OUT,
    // register memory side
    output logic [7:0] MEM_ADDR_OUT,
    output logic [7:0] MEM_WDATA_OUT,
    output logic MEM_WR_OUT,
    output logic MEM_RD_OUT,
    input wire logic [7:0] MEM_RDATA_IN,
    // status
    output logic BUSY_OUT,
    output two_wire_pkg::bus_state_type STATE_OUT
);
    import two_wire_pkg::*;

    // states in which the port receives a byte and may acknowledge it
    function automatic logic is_rx_state(input bus_state_type st);
        is_rx_state = (st == ST_ADDR) || (st == ST_PTR) || (st == ST_WRITE);
    endfunction

    logic [7:0] shift_link;
    logic toggle_link;
    logic [2:0] sync_bus;
    logic scl_s;
    logic sda_s;
    logic tog_s;

    link_bit_capture u_capture (
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .rstn_in(RSTN_IN),
        .shift_out(shift_link),
        .toggle_out(toggle_link)
    );

    level_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .async_in({SCL_IN, SDA_IN, toggle_link}),
        .sync_out(sync_bus)
    );

    assign scl_s = sync_bus[2];
    assign sda_s = sync_bus[1];
    assign tog_s = sync_bus[0];

    // front: previous synchronised levels and event decoding
    logic scl_p_q;
    logic scl_p_d;
    logic sda_p_q;
    logic sda_p_d;
    logic tog_p_q;
    logic tog_p_d;
    logic primed_q;
    logic primed_d;
    logic start_evt;
    logic stop_evt;
    logic rise_evt;
    logic fall_evt;

    always_comb
    begin
        scl_p_d = scl_s;
        sda_p_d = sda_s;
        tog_p_d = tog_s;
        primed_d = 1'b1;
        // data edges only count while the clock is high on both samples
        start_evt = primed_q && scl_s && scl_p_q && sda_p_q && !sda_s;
        stop_evt = primed_q && scl_s && scl_p_q && !sda_p_q && sda_s;
        fall_evt = primed_q && scl_p_q && !scl_s;
        // the shifter is stable for a whole clock high time once the toggle shows
        rise_evt = primed_q && (tog_s != tog_p_q);
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            tog_p_q <= 1'b0;
            primed_q <= 1'b0;
        end
        else
        begin
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
            tog_p_q <= tog_p_d;
            primed_q <= primed_d;
        end
    end

    // protocol state
    bus_state_type state_q;
    bus_state_type state_d;
    logic [3:0] slot_q;
    logic [3:0] slot_d;
    logic ack_q;
    logic ack_d;
    logic read_q;
    logic read_d;
    logic wr_ok_q;
    logic wr_ok_d;
    logic [7:0] wbyte_q;
    logic [7:0] wbyte_d;
    logic [7:0] waddr_q;
    logic [7:0] waddr_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic over_q;
    logic over_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic rd_pend_q;
    logic rd_pend_d;
    logic oe_q;
    logic oe_d;
    logic sda_out_q;
    logic sda_out_d;
    logic [6:0] dev_addr_q;
    logic [6:0] dev_addr_d;
    logic [7:0] mem_addr_q;
    logic [7:0] mem_addr_d;
    logic [7:0] mem_wdata_q;
    logic [7:0] mem_wdata_d;
    logic mem_wr_q;
    logic mem_wr_d;
    logic mem_rd_q;
    logic mem_rd_d;
    logic busy_q;
    logic busy_d;

    always_comb
    begin
        state_d = state_q;
        slot_d = slot_q;
        ack_d = ack_q;
        read_d = read_q;
        wr_ok_d = wr_ok_q;
        wbyte_d = wbyte_q;
        waddr_d = waddr_q;
        ptr_d = ptr_q;
        over_d = over_q;
        tx_d = tx_q;
        rd_pend_d = mem_rd_q;
        oe_d = oe_q;
        // open drain: the driven level is always low
        sda_out_d = 1'b0;
        dev_addr_d = dev_addr_q;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        mem_wr_d = 1'b0;
        mem_rd_d = 1'b0;

        if (ADDR_WR_IN)
        begin
            dev_addr_d = ADDR_VAL_IN;
        end

        // read data arrives one cycle after the strobe
        if (rd_pend_q)
        begin
            tx_d = MEM_RDATA_IN;
        end

        if (stop_evt)
        begin
            // a half-received byte is simply dropped here
            state_d = ST_IDLE;
            slot_d = `TW_SLOT_ZERO;
            oe_d = 1'b0;
        end
        else if (start_evt)
        begin
            // also taken mid-transfer, which is the repeated start case
            state_d = ST_ADDR;
            slot_d = `TW_SLOT_ZERO;
            ack_d = 1'b0;
            oe_d = 1'b0;
        end
        else if (rise_evt && (state_q != ST_IDLE) && (state_q != ST_IGNORE))
        begin
            if (slot_q == `TW_ACK_SLOT)
            begin
                slot_d = `TW_SLOT_ZERO;
                unique case (state_q)
                    ST_ADDR:
                    begin
                        if (!ack_q)
                        begin
                            state_d = ST_IGNORE;
                        end
                        else if (read_q)
                        begin
                            state_d = ST_READ;
                        end
                        else
                        begin
                            state_d = ST_PTR;
                        end
                    end
                    ST_PTR:
                    begin
                        state_d = ST_WRITE;
                    end
                    ST_WRITE:
                    begin
                        // commit only a complete byte this port acknowledged
                        mem_addr_d = waddr_q;
                        mem_wdata_d = wbyte_q;
                        mem_wr_d = wr_ok_q && ack_q;
                    end
                    ST_READ:
                    begin
                        // the master's bit is the last one shifted in
                        if (shift_link[0])
                        begin
                            state_d = ST_IGNORE;
                        end
                    end
                    default:
                    begin
                        state_d = ST_IDLE;
                    end
                endcase
            end
            else
            begin
                slot_d = slot_q + `TW_SLOT_STEP;
                if (slot_q == `TW_LSB_SLOT)
                begin
                    unique case (state_q)
                        ST_ADDR:
                        begin
                            ack_d = (shift_link[7:1] == dev_addr_q);
                            read_d = shift_link[0];
                            if ((shift_link[7:1] == dev_addr_q) && shift_link[0])
                            begin
                                mem_addr_d = ptr_q;
                                mem_rd_d = !over_q;
                                tx_d = `TW_READ_FILL;
                            end
                        end
                        ST_PTR:
                        begin
                            ptr_d = shift_link;
                            over_d = 1'b0;
                            ack_d = 1'b1;
                        end
                        ST_WRITE:
                        begin
                            wbyte_d = shift_link;
                            waddr_d = ptr_q;
                            wr_ok_d = !over_q && (ptr_q <= `TW_WRITE_LAST);
                            ack_d = 1'b1;
                            ptr_d = ptr_q + `TW_PTR_STEP;
                            over_d = over_q || (ptr_q == `TW_PTR_LAST);
                        end
                        ST_READ:
                        begin
                            // fetch the next byte on the rise of the last data bit, before the master acknowledges
                            ptr_d = ptr_q + `TW_PTR_STEP;
                            over_d = over_q || (ptr_q == `TW_PTR_LAST);
                            mem_addr_d = ptr_q + `TW_PTR_STEP;
                            mem_rd_d = !(over_q || (ptr_q == `TW_PTR_LAST));
                            tx_d = `TW_READ_FILL;
                        end
                        default:
                        begin
                            state_d = ST_IDLE;
                        end
                    endcase
                end
            end
        end
        else if (fall_evt && (state_q != ST_IDLE) && (state_q != ST_IGNORE))
        begin
            // the line only moves while the clock is low
            if (slot_q == `TW_ACK_SLOT)
            begin
                // the master acknowledges read data, so stay off the line
                oe_d = is_rx_state(state_q) && ack_q;
            end
            else if (state_q == ST_READ)
            begin
                oe_d = !tx_q[7];
                tx_d = {tx_q[6:0], 1'b1};
            end
            else
            begin
                oe_d = 1'b0;
            end
        end
        else if ((state_q == ST_IDLE) || (state_q == ST_IGNORE))
        begin
            oe_d = 1'b0;
        end

        busy_d = (state_d != ST_IDLE) && (state_d != ST_IGNORE);
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            state_q <= ST_IDLE;
            slot_q <= `TW_SLOT_ZERO;
            ack_q <= 1'b0;
            read_q <= 1'b0;
            wr_ok_q <= 1'b0;
            wbyte_q <= 8'h00;
            waddr_q <= 8'h00;
            ptr_q <= 8'h00;
            over_q <= 1'b0;
            tx_q <= 8'hFF;
            rd_pend_q <= 1'b0;
            oe_q <= 1'b0;
            sda_out_q <= 1'b0;
            dev_addr_q <= `TW_ADDR_DEFAULT;
            mem_addr_q <= 8'h00;
            mem_wdata_q <= 8'h00;
            mem_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            slot_q <= slot_d;
            ack_q <= ack_d;
            read_q <= read_d;
            wr_ok_q <= wr_ok_d;
            wbyte_q <= wbyte_d;
            waddr_q <= waddr_d;
            ptr_q <= ptr_d;
            over_q <= over_d;
            tx_q <= tx_d;
            rd_pend_q <= rd_pend_d;
            oe_q <= oe_d;
            sda_out_q <= sda_out_d;
            dev_addr_q <= dev_addr_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
            mem_wr_q <= mem_wr_d;
            mem_rd_q <= mem_rd_d;
            busy_q <= busy_d;
        end
    end

    assign SDA_OUT = sda_out_q;
    assign SDA_OE_OUT = oe_q;
    assign DEV_ADDR_OUT = dev_addr_q;
    assign MEM_ADDR_OUT = mem_addr_q;
    assign MEM_WDATA_OUT = mem_wdata_q;
    assign MEM_WR_OUT = mem_wr_q;
    assign MEM_RD_OUT = mem_rd_q;
    assign BUSY_OUT = busy_q;
    assign STATE_OUT = state_q;
endmodule

// ---- bench/two_wire_slave_port_properties.sv ----
/*
 concurrent checks on the two-wire slave port, seen from its ports only.
 assumes a single clock domain on CLK_IN; the serial lines are sampled raw.
*/
`timescale 1ns/10ps
`include "two_wire_map.svh"
module two_wire_slave_port_checker (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // serial link
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_OUT,
    // address programming
    input wire logic ADDR_WR_IN,
    input wire logic [6:0] ADDR_VAL_IN,
    input wire logic [6:0] DEV_ADDR_OUT,
    // memory side
    input wire logic [7:0] MEM_ADDR_OUT,
    input wire logic MEM_WR_OUT,
    input wire logic MEM_RD_OUT,
    // status
    input wire two_wire_pkg::bus_state_type STATE_OUT
);
    import two_wire_pkg::*;

    default clocking @(posedge CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    chk_sda_low_only: assert property (SDA_OUT == 1'b0)
        else $error("data drive value not low");
    // bounds cover two synchroniser flops, the double sample and the state register
    chk_start_to_addr: assert property ((SCL_IN && $fell(SDA_IN)) ##1 (SCL_IN && !SDA_IN) [*3]
        |-> ##[1:6] (STATE_OUT == ST_ADDR))
        else $error("start not decoded");
    chk_stop_to_idle: assert property ((SCL_IN && $rose(SDA_IN)) ##1 (SCL_IN && SDA_IN) [*3]
        |-> ##[1:6] (STATE_OUT == ST_IDLE))
        else $error("stop not decoded");
    chk_oe_clock_low: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
        else $error("data drive changed with clock high");
    chk_quiet_released: assert property ((STATE_OUT inside {ST_IDLE, ST_IGNORE}) [*2]
        |-> !SDA_OE_OUT)
        else $error("data line pulled while not addressed");
    chk_write_acked: assert property (MEM_WR_OUT |-> SDA_OE_OUT && SCL_IN)
        else $error("write strobe outside own acknowledge");
    chk_write_window: assert property (MEM_WR_OUT
        |-> (STATE_OUT == ST_WRITE) && (MEM_ADDR_OUT <= `TW_WRITE_LAST))
        else $error("write strobe out of place");
    chk_strobe_single: assert property (MEM_WR_OUT |=> !MEM_WR_OUT)
        else $error("write strobe too long");
    chk_read_single: assert property (MEM_RD_OUT |=> !MEM_RD_OUT ##1 !MEM_RD_OUT)
        else $error("read strobe repeated");
    chk_addr_load: assert property (ADDR_WR_IN |=> (DEV_ADDR_OUT == $past(ADDR_VAL_IN)))
        else $error("device address not loaded");

    cov_write: cover property (MEM_WR_OUT);
    cov_read: cover property (MEM_RD_OUT);
    cov_ignore: cover property (STATE_OUT == ST_IGNORE);
    cov_reprog: cover property (ADDR_WR_IN);
endmodule

// ---- bench/two_wire_master_model.sv ----
/*
 two-wire bus master model timed by its own 12 ns link tick.
 assumes the data line is resolved with a pull-up outside.
*/
`timescale 1ns/10ps
module two_wire_master_model (
    // resolved data line
    input wire logic sda_in,
    // master drive
    output logic scl_out,
    output logic pull_out
);
    logic tick_clk;
    // released lines idle high; the tick is offset so it never aligns with CLK_IN
    initial
    begin
        scl_out = 1'b1;
        pull_out = 1'b0;
        tick_clk = 1'b0;
        #2.7;
        forever #6 tick_clk = ~tick_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge tick_clk);
    endtask
    task automatic start_cond();
        pull_out <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        pull_out <= 1'b1;
        tick(3);
        scl_out <= 1'b0;
        tick(3);
    endtask
    task automatic stop_cond();
        pull_out <= 1'b1;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        pull_out <= 1'b0;
        tick(3);
    endtask
    // data moves only while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        pull_out <= ~b;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        s = sda_in;
        tick(3);
        scl_out <= 1'b0;
        tick(3);
    endtask
    task automatic wr_byte(input logic [7:0] b, input int n, output logic ack);
        logic s;
        s = 1'b1;
        for (int i = 0; i < n; i++)
            clk_bit(b[7 - i], s);
        if (n == 8)
            clk_bit(1'b1, s);
        ack = (n == 8) ? ~s : 1'b0;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] v);
        logic s;
        v = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            clk_bit(1'b1, s);
            v = {v[6:0], s};
        end
        clk_bit(last, s);
    endtask
endmodule

// ---- bench/two_wire_slave_port_test.sv ----
/*
 self-checking bench of the two-wire slave port with a master model.
 assumes a one-cycle memory answering the read strobe, modelled here.
*/
`timescale 1ns/10ps
module two_wire_slave_port_test;
    import two_wire_pkg::*;
    logic clk;
    logic rstn = 1'b0;
    logic addr_wr = 1'b0;
    logic [6:0] addr_val = 7'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic scl, m_pull, sda_out, sda_oe, mem_wr, mem_rd, busy;
    logic [6:0] dev_addr;
    logic [7:0] mem_addr, mem_wdata;
    bus_state_type state;
    wire logic sda = !(sda_oe | m_pull);
    logic [7:0] wa[$];
    logic [7:0] wd[$];
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    two_wire_slave_port dut (.CLK_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .ADDR_WR_IN(addr_wr), .ADDR_VAL_IN(addr_val),
        .DEV_ADDR_OUT(dev_addr), .MEM_ADDR_OUT(mem_addr), .MEM_WDATA_OUT(mem_wdata),
        .MEM_WR_OUT(mem_wr), .MEM_RD_OUT(mem_rd), .MEM_RDATA_IN(mem_rdata),
        .BUSY_OUT(busy), .STATE_OUT(state));
    two_wire_master_model m (.sda_in(sda), .scl_out(scl), .pull_out(m_pull));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [7:0] mem_val(input logic [7:0] a);
        return a ^ 8'h5A;
    endfunction
    // memory answers one cycle after the strobe and logs every commit
    always @(posedge clk)
    begin
        if (mem_rd === 1'b1)
            mem_rdata <= mem_val(mem_addr);
        if (mem_wr === 1'b1)
        begin
            wa.push_back(mem_addr);
            wd.push_back(mem_wdata);
        end
    end
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // whole run is near 8800 cycles; the ceiling leaves room
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            fails++;
            test_done();
        end
    end
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic t_probe();
        logic ack;
        check(dev_addr === 7'h34 && sda_oe === 1'b0, "reset state");
        m.start_cond();
        m.wr_byte({7'h34, 1'b0}, 8, ack);
        check(ack === 1'b1 && busy === 1'b1, "own address not acked");
        m.stop_cond();
        repeat (10) @(posedge clk);
        check(state === ST_IDLE && busy === 1'b0, "not idle after stop");
        m.start_cond();
        m.wr_byte({7'h35, 1'b0}, 8, ack);
        check(ack === 1'b0, "foreign address acked");
        m.wr_byte(8'h00, 8, ack);
        check(ack === 1'b0 && state === ST_IGNORE && busy === 1'b0, "foreign traffic answered");
        m.stop_cond();
    endtask
    task automatic t_write();
        logic ack;
        wa.delete();
        wd.delete();
        m.start_cond();
        m.wr_byte(8'h68, 8, ack);
        m.wr_byte(8'h4E, 8, ack);
        for (int i = 1; i <= 3; i++)
        begin
            m.wr_byte(8'h11 * i, 8, ack);
            check(ack === 1'b1, "data byte not acked");
        end
        m.stop_cond();
        check(wa.size() == 2, "wrong commit count");
        check(wa[0] === 8'h4E && wd[0] === 8'h11, "first byte");
        check(wa[1] === 8'h4F && wd[1] === 8'h22, "second byte");
    endtask
    task automatic t_read();
        logic ack;
        logic [7:0] v;
        m.start_cond();
        m.wr_byte(8'h68, 8, ack);
        m.wr_byte(8'hFE, 8, ack);
        m.start_cond();
        m.wr_byte(8'h69, 8, ack);
        check(ack === 1'b1, "read address not acked");
        m.rd_byte(1'b0, v);
        check(v === mem_val(8'hFE), "read byte at pointer");
        m.rd_byte(1'b0, v);
        check(v === mem_val(8'hFF), "read byte after step");
        m.rd_byte(1'b1, v);
        check(v === 8'hFF, "read past end");
        check(sda_oe === 1'b0, "line held after nak");
        m.stop_cond();
    endtask
    task automatic t_abort();
        logic ack;
        wa.delete();
        wd.delete();
        m.start_cond();
        m.wr_byte(8'h68, 8, ack);
        m.wr_byte(8'h10, 8, ack);
        m.wr_byte(8'hC3, 4, ack);
        m.stop_cond();
        check(wa.size() == 0, "partial byte stored");
        m.start_cond();
        m.wr_byte(8'h68, 8, ack);
        m.wr_byte(8'h10, 8, ack);
        m.wr_byte(8'h5C, 8, ack);
        m.start_cond();
        m.wr_byte(8'h68, 8, ack);
        m.wr_byte(8'h20, 8, ack);
        m.wr_byte(8'hA7, 8, ack);
        m.stop_cond();
        check(wa.size() == 2 && wa[1] === 8'h20 && wd[1] === 8'hA7, "after restart");
        check(wa[0] === 8'h10 && wd[0] === 8'h5C, "before restart");
    endtask
    task automatic t_reprog();
        logic ack;
        logic [7:0] v;
        @(posedge clk);
        addr_wr <= 1'b1;
        addr_val <= 7'h12;
        @(posedge clk);
        addr_wr <= 1'b0;
        @(posedge clk);
        check(dev_addr === 7'h12, "address not loaded");
        m.start_cond();
        m.wr_byte({7'h34, 1'b0}, 8, ack);
        check(ack === 1'b0, "old address acked");
        // missing acknowledge: the master retries with a fresh start
        m.start_cond();
        m.wr_byte({7'h12, 1'b1}, 8, ack);
        check(ack === 1'b1, "new address not acked");
        m.rd_byte(1'b1, v);
        check(v === mem_val(8'h21), "read direction data");
        m.stop_cond();
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        t_probe();
        t_write();
        t_read();
        t_abort();
        t_reprog();
        test_done();
    end
endmodule

bind two_wire_slave_port two_wire_slave_port_checker chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
    .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
    .ADDR_WR_IN(ADDR_WR_IN), .ADDR_VAL_IN(ADDR_VAL_IN), .DEV_ADDR_OUT(DEV_ADDR_OUT),
    .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_WR_OUT(MEM_WR_OUT), .MEM_RD_OUT(MEM_RD_OUT),
    .STATE_OUT(STATE_OUT));
